// ### core/icfr_pkg.sv
// package of register map, field positions and reset values for the interrupt control block
package icfr_pkg;
	// register byte offsets on apb (none printed, chosen here)
	localparam logic [7:0] ICFR_OFF_MAIN   = 8'h00;
	localparam logic [7:0] ICFR_OFF_EDGPRI = 8'h04;
	localparam logic [7:0] ICFR_OFF_EXTLN  = 8'h08;
	localparam logic [7:0] ICFR_OFF_PFLAG1 = 8'h0c;
	localparam logic [7:0] ICFR_OFF_MODE   = 8'h10;
	localparam logic [7:0] ICFR_OFF_STATUS = 8'h14;
	// main control register fields
	localparam int ICFR_MAIN_GEN   = 7;
	localparam int ICFR_MAIN_PEN   = 6;
	localparam int ICFR_MAIN_T0E   = 5;
	localparam int ICFR_MAIN_X0E   = 4;
	localparam int ICFR_MAIN_PCE   = 3;
	localparam int ICFR_MAIN_T0F   = 2;
	localparam int ICFR_MAIN_X0F   = 1;
	localparam int ICFR_MAIN_PCF   = 0;
	// edge / priority register fields
	localparam int ICFR_EP_PUD     = 7;
	localparam int ICFR_EP_EDG0    = 6;
	localparam int ICFR_EP_EDG1    = 5;
	localparam int ICFR_EP_EDG2    = 4;
	localparam int ICFR_EP_T0P     = 2;
	localparam int ICFR_EP_PCP     = 0;
	localparam logic [7:0] ICFR_EP_MASK  = 8'hf5;
	// external line register fields
	localparam int ICFR_XL_X2P     = 7;
	localparam int ICFR_XL_X1P     = 6;
	localparam int ICFR_XL_X2E     = 4;
	localparam int ICFR_XL_X1E     = 3;
	localparam int ICFR_XL_X2F     = 1;
	localparam int ICFR_XL_X1F     = 0;
	localparam logic [7:0] ICFR_XL_MASK  = 8'hdb;
	// peripheral flag register 1 fields
	localparam int ICFR_PF_PSP     = 7;
	localparam int ICFR_PF_CNV     = 6;
	localparam int ICFR_PF_RX      = 5;
	localparam int ICFR_PF_TX      = 4;
	localparam int ICFR_PF_SSP     = 3;
	localparam logic [7:0] ICFR_PF_MASK  = 8'hc8;
	// reset values
	localparam logic [7:0] ICFR_RST_MAIN   = 8'h00;
	localparam logic [7:0] ICFR_RST_EDGPRI = 8'hf5;
	localparam logic [7:0] ICFR_RST_EXTLN  = 8'hc0;
	localparam logic [7:0] ICFR_RST_PFLAG1 = 8'h00;
	// service levels held by the block
	typedef enum logic [1:0] {ICFR_IDLE, ICFR_LOW, ICFR_HIGH, ICFR_HIGH_OVER_LOW} icfr_svc_t;
endpackage : icfr_pkg

// ### core/icfr_top.sv
// interrupt control and flag registers with apb slave and request logic
`timescale 1ns/1ps
module icfr_top
	import icfr_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer0_wrap,
	input  wire logic [2:0]  ext_line_pin,
	input  wire logic [3:0]  upper_port_pins,
	input  wire logic        port_b_read,
	input  wire logic        parallel_port_access,
	input  wire logic        converter_done,
	input  wire logic        serial_rx_full,
	input  wire logic        serial_tx_empty,
	input  wire logic        sync_serial_done,
	input  wire logic        irq_ack,
	input  wire logic        irq_return,
	output logic             irq_high_req,
	output logic             irq_low_req,
	output logic             port_pullup_disable
);
	typedef struct packed {
		logic [7:0]  main;
		logic [7:0]  edgpri;
		logic [7:0]  extln;
		logic [7:0]  pflag;
		logic        prio_mode;
		logic [2:0]  ext_s1;
		logic [2:0]  ext_s2;
		logic [2:0]  ext_old;
		logic [3:0]  prt_s1;
		logic [3:0]  prt_s2;
		logic [3:0]  prt_latch;
		logic [2:0]  arm;
		icfr_svc_t   svc;
		logic [31:0] rdata;
		logic        ready;
		logic        err;
		logic        hreq;
		logic        lreq;
		logic        pud;
	} icfr_state_t;

	icfr_state_t st_q;
	icfr_state_t st_d;

	// source pending with its enable
	logic t0_act, x0_act, pc_act, x1_act, x2_act;
	logic any_hi, any_lo, any_compat, per_act;
	logic [2:0] edge_sel;
	logic [2:0] ext_event;
	logic       pc_mismatch;
	logic       setup_wr, setup_rd;

	// read mux for the six registers, undefined offsets error
	function automatic logic [8:0] icfr_read(input icfr_state_t s, input logic [7:0] a);
		logic [8:0] r;
		r = 9'h000;
		if (a == ICFR_OFF_MAIN) begin
			r = {1'b0, s.main};
		end else if (a == ICFR_OFF_EDGPRI) begin
			r = {1'b0, s.edgpri & ICFR_EP_MASK};
		end else if (a == ICFR_OFF_EXTLN) begin
			r = {1'b0, s.extln & ICFR_XL_MASK};
		end else if (a == ICFR_OFF_PFLAG1) begin
			r = {1'b0, s.pflag};
		end else if (a == ICFR_OFF_MODE) begin
			r = {8'h00, s.prio_mode};
		end else if (a == ICFR_OFF_STATUS) begin
			r = {7'h00, s.svc};
		end else begin
			r = 9'h100;
		end
		return r;
	endfunction : icfr_read

	// events and combined request terms
	always_comb begin
		edge_sel  = {st_q.edgpri[ICFR_EP_EDG2], st_q.edgpri[ICFR_EP_EDG1],
			st_q.edgpri[ICFR_EP_EDG0]};
		// rising when select 1, falling when 0; held off until history is primed
		ext_event = ((st_q.ext_s2 & ~st_q.ext_old & edge_sel) |
			(~st_q.ext_s2 & st_q.ext_old & ~edge_sel)) & {3{st_q.arm[2]}};
		pc_mismatch = (st_q.prt_s2 != st_q.prt_latch);
		setup_wr = psel && !penable && pwrite;
		setup_rd = psel && !penable && !pwrite;
		t0_act = st_q.main[ICFR_MAIN_T0F] && st_q.main[ICFR_MAIN_T0E];
		x0_act = st_q.main[ICFR_MAIN_X0F] && st_q.main[ICFR_MAIN_X0E];
		pc_act = st_q.main[ICFR_MAIN_PCF] && st_q.main[ICFR_MAIN_PCE];
		x1_act = st_q.extln[ICFR_XL_X1F] && st_q.extln[ICFR_XL_X1E];
		x2_act = st_q.extln[ICFR_XL_X2F] && st_q.extln[ICFR_XL_X2E];
		// peripheral enables live outside; any set peripheral flag counts
		per_act = |(st_q.pflag & ICFR_PF_MASK) | st_q.pflag[ICFR_PF_RX] |
			st_q.pflag[ICFR_PF_TX];
		// external line 0 is always high priority
		any_hi = x0_act || (t0_act && st_q.edgpri[ICFR_EP_T0P]) ||
			(pc_act && st_q.edgpri[ICFR_EP_PCP]) ||
			(x1_act && st_q.extln[ICFR_XL_X1P]) ||
			(x2_act && st_q.extln[ICFR_XL_X2P]);
		any_lo = (t0_act && !st_q.edgpri[ICFR_EP_T0P]) ||
			(pc_act && !st_q.edgpri[ICFR_EP_PCP]) ||
			(x1_act && !st_q.extln[ICFR_XL_X1P]) ||
			(x2_act && !st_q.extln[ICFR_XL_X2P]) || per_act;
		// peripheral group gated by bit 6 in compatibility mode
		any_compat = x0_act || t0_act || pc_act || x1_act || x2_act ||
			(per_act && st_q.main[ICFR_MAIN_PEN]);
	end

	// next state: registers, flags, service level, bus answer
	always_comb begin
		logic [8:0] rd;
		rd = 9'h000;
		st_d = st_q;
		st_d.ext_s1  = ext_line_pin;
		st_d.ext_s2  = st_q.ext_s1;
		st_d.ext_old = st_q.ext_s2;
		// primed over three edges: a pin idling high after reset is no edge
		st_d.arm     = {st_q.arm[1:0], 1'b1};
		st_d.prt_s1  = upper_port_pins;
		st_d.prt_s2  = st_q.prt_s1;
		st_d.ready   = 1'b0;
		st_d.err     = 1'b0;
		// reading the port ends the mismatch
		if (port_b_read) begin
			st_d.prt_latch = st_q.prt_s2;
		end
		// apb: answer one cycle after setup, zero wait in access
		if (setup_wr || setup_rd) begin
			rd = icfr_read(st_q, paddr);
			st_d.ready = 1'b1;
			st_d.err   = rd[8];
			st_d.rdata = {24'h000000, rd[7:0]};
		end
		// writes land at setup; set terms below override clears
		if (setup_wr) begin
			if (paddr == ICFR_OFF_MAIN) begin
				st_d.main = pwdata[7:0];
			end else if (paddr == ICFR_OFF_EDGPRI) begin
				st_d.edgpri = pwdata[7:0] & ICFR_EP_MASK;
			end else if (paddr == ICFR_OFF_EXTLN) begin
				st_d.extln = pwdata[7:0] & ICFR_XL_MASK;
			end else if (paddr == ICFR_OFF_PFLAG1) begin
				st_d.pflag = pwdata[7:0] & ICFR_PF_MASK;
			end else if (paddr == ICFR_OFF_MODE) begin
				st_d.prio_mode = pwdata[0];
			end
		end
		// hardware sets after writes so they win
		if (timer0_wrap) st_d.main[ICFR_MAIN_T0F] = 1'b1;
		if (ext_event[0]) st_d.main[ICFR_MAIN_X0F] = 1'b1;
		if (pc_mismatch) st_d.main[ICFR_MAIN_PCF] = 1'b1;
		if (ext_event[1]) st_d.extln[ICFR_XL_X1F] = 1'b1;
		if (ext_event[2]) st_d.extln[ICFR_XL_X2F] = 1'b1;
		if (parallel_port_access) st_d.pflag[ICFR_PF_PSP] = 1'b1;
		if (converter_done) st_d.pflag[ICFR_PF_CNV] = 1'b1;
		if (sync_serial_done) st_d.pflag[ICFR_PF_SSP] = 1'b1;
		st_d.pflag[ICFR_PF_RX] = serial_rx_full;
		st_d.pflag[ICFR_PF_TX] = serial_tx_empty;
		// requests from current state
		if (!st_q.prio_mode) begin
			st_d.hreq = st_q.main[ICFR_MAIN_GEN] && any_compat &&
				(st_q.svc == ICFR_IDLE);
			st_d.lreq = 1'b0;
		end else begin
			st_d.hreq = st_q.main[ICFR_MAIN_GEN] && any_hi &&
				(st_q.svc != ICFR_HIGH) && (st_q.svc != ICFR_HIGH_OVER_LOW);
			st_d.lreq = st_q.main[ICFR_MAIN_PEN] && any_lo &&
				(st_q.svc == ICFR_IDLE) && !st_d.hreq;
		end
		// core takes an interrupt; admitting enable drops
		if (irq_ack && st_q.hreq) begin
			st_d.main[ICFR_MAIN_GEN] = 1'b0;
			st_d.hreq = 1'b0;
			st_d.lreq = 1'b0;
			st_d.svc  = (st_q.svc == ICFR_LOW) ? ICFR_HIGH_OVER_LOW : ICFR_HIGH;
		end else if (irq_ack && st_q.lreq) begin
			st_d.main[ICFR_MAIN_PEN] = 1'b0;
			st_d.lreq = 1'b0;
			st_d.svc  = ICFR_LOW;
		end else if (irq_return) begin
			// return re-enables the level that was being served
			case (st_q.svc)
				ICFR_HIGH: begin
					st_d.main[ICFR_MAIN_GEN] = 1'b1;
					st_d.svc = ICFR_IDLE;
				end
				ICFR_HIGH_OVER_LOW: begin
					st_d.main[ICFR_MAIN_GEN] = 1'b1;
					st_d.svc = ICFR_LOW;
				end
				ICFR_LOW: begin
					st_d.main[ICFR_MAIN_PEN] = 1'b1;
					st_d.svc = ICFR_IDLE;
				end
				default: begin
					st_d.svc = ICFR_IDLE;
				end
			endcase
		end
		// pin level follows the written bit in the same cycle
		st_d.pud = st_d.edgpri[ICFR_EP_PUD];
	end

	// single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
			st_q.main   <= ICFR_RST_MAIN;
			st_q.edgpri <= ICFR_RST_EDGPRI;
			st_q.extln  <= ICFR_RST_EXTLN;
			st_q.pflag  <= ICFR_RST_PFLAG1;
			st_q.pud    <= 1'b1;
			st_q.svc    <= ICFR_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs come straight from the state register
	assign prdata              = st_q.rdata;
	assign pready              = st_q.ready;
	assign pslverr             = st_q.err;
	assign irq_high_req        = st_q.hreq;
	assign irq_low_req         = st_q.lreq;
	assign port_pullup_disable = st_q.pud;

	// timer wrap sets its flag next edge
	property p_t0_set;
		@(posedge pclk) disable iff (!presetn) timer0_wrap |=> st_q.main[ICFR_MAIN_T0F];
	endproperty
	a_t0_set: assert property (p_t0_set) else $error("timer flag not set");

	// only software clears an external line flag
	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
			st_q.extln[ICFR_XL_X1F] && !setup_wr |=> st_q.extln[ICFR_XL_X1F];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("line1 flag lost");

	// a clear racing a completion must not lose the event
	property p_set_wins;
		@(posedge pclk) disable iff (!presetn)
			setup_wr && paddr == ICFR_OFF_PFLAG1 && converter_done
			|=> st_q.pflag[ICFR_PF_CNV];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat set");

	property p_compat_block;
		@(posedge pclk) disable iff (!presetn)
			!st_q.prio_mode && !$past(st_q.main[ICFR_MAIN_GEN]) |-> !irq_high_req;
	endproperty
	a_compat_block: assert property (p_compat_block) else $error("req while disabled");

	// low level held off while high is in service
	property p_low_waits;
		@(posedge pclk) disable iff (!presetn) st_q.svc == ICFR_HIGH |=> !irq_low_req;
	endproperty
	a_low_waits: assert property (p_low_waits) else $error("low during high");

	property p_ack_clears;
		@(posedge pclk) disable iff (!presetn)
			irq_ack && irq_high_req |=> !st_q.main[ICFR_MAIN_GEN];
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("enable kept");

	// unimplemented positions read back as zero
	property p_rsvd_zero;
		@(posedge pclk) disable iff (!presetn)
			pready && !pwrite && paddr == ICFR_OFF_EDGPRI |-> prdata[3] == 1'b0 && prdata[1] == 1'b0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

	// receive flag mirrors the buffer level a cycle later
	property p_rx_follow;
		@(posedge pclk) disable iff (!presetn)
			serial_rx_full ##1 serial_rx_full |-> st_q.pflag[ICFR_PF_RX];
	endproperty
	a_rx_follow: assert property (p_rx_follow) else $error("rx flag wrong");

	// pin output tracks its register bit
	property p_pud;
		@(posedge pclk) disable iff (!presetn)
			port_pullup_disable == st_q.edgpri[ICFR_EP_PUD] || $changed(st_q.edgpri);
	endproperty
	a_pud: assert property (p_pud) else $error("pull-up mismatch");

	// gates act one cycle late because requests are registered
	property p_high_gate;
		@(posedge pclk) disable iff (!presetn)
			!$past(st_q.main[ICFR_MAIN_GEN]) |-> !irq_high_req;
	endproperty
	a_high_gate: assert property (p_high_gate) else $error("high req while gated");

	property p_low_gate;
		@(posedge pclk) disable iff (!presetn)
			!$past(st_q.main[ICFR_MAIN_PEN]) |-> !irq_low_req;
	endproperty
	a_low_gate: assert property (p_low_gate) else $error("low req while gated");

	property p_low_ack;
		@(posedge pclk) disable iff (!presetn)
			irq_ack && irq_low_req && !irq_high_req |=> !st_q.main[ICFR_MAIN_PEN];
	endproperty
	a_low_ack: assert property (p_low_ack) else $error("low enable kept");

	property p_pc_set;
		@(posedge pclk) disable iff (!presetn)
			st_q.prt_s2 != st_q.prt_latch |=> st_q.main[ICFR_MAIN_PCF];
	endproperty
	a_pc_set: assert property (p_pc_set) else $error("port flag not set");

	property p_x0_set;
		@(posedge pclk) disable iff (!presetn)
			st_q.arm[2] && st_q.edgpri[ICFR_EP_EDG0] &&
			st_q.ext_s2[0] && !st_q.ext_old[0] |=> st_q.main[ICFR_MAIN_X0F];
	endproperty
	a_x0_set: assert property (p_x0_set) else $error("line0 edge lost");

	property p_tx_follow;
		@(posedge pclk) disable iff (!presetn)
			!serial_tx_empty |=> !st_q.pflag[ICFR_PF_TX];
	endproperty
	a_tx_follow: assert property (p_tx_follow) else $error("tx flag held");

	property p_cnv_set;
		@(posedge pclk) disable iff (!presetn) converter_done |=> st_q.pflag[ICFR_PF_CNV];
	endproperty
	a_cnv_set: assert property (p_cnv_set) else $error("converter flag lost");

	property p_answer;
		@(posedge pclk) disable iff (!presetn) psel && !penable |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no ready after setup");

	c_high_req: cover property (@(posedge pclk) disable iff (!presetn) irq_high_req);
	c_low_ack: cover property (@(posedge pclk) disable iff (!presetn) irq_ack && irq_low_req);
	c_low_req: cover property (@(posedge pclk) disable iff (!presetn) irq_low_req);
	c_nest: cover property (@(posedge pclk) disable iff (!presetn)
		st_q.svc == ICFR_HIGH_OVER_LOW);
endmodule : icfr_top

// ### sim/icfr_core_model.sv
// behavioural core model: takes requests and returns from service
`timescale 1ns/1ps
module icfr_core_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       irq_high_req,
	input  wire logic       irq_low_req,
	input  wire logic       en,
	input  wire logic [3:0] dly,
	input  wire logic       ret_en,
	output logic            irq_ack,
	output logic            irq_return
);
	logic [3:0] cnt_q;
	logic [1:0] rc_q;
	logic       pend_q;
	// ack after dly+1 cycles of a standing request; one return for all acks since the last return, only when allowed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack    <= 1'b0;
			irq_return <= 1'b0;
			cnt_q      <= 4'h0;
			rc_q       <= 2'h0;
			pend_q     <= 1'b0;
		end else begin
			irq_ack    <= 1'b0;
			irq_return <= 1'b0;
			// no second ack while the first is still in flight
			if (en && (irq_high_req || irq_low_req) && !irq_ack) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == dly) begin
					irq_ack <= 1'b1;
					cnt_q   <= 4'h0;
					pend_q  <= 1'b1;
				end
			end else begin
				cnt_q <= 4'h0;
			end
			if (pend_q && ret_en) begin
				rc_q <= rc_q + 2'h1;
				if (rc_q == 2'h3) begin
					irq_return <= 1'b1;
					pend_q     <= 1'b0;
				end
			end
		end
	end
endmodule : icfr_core_model

// ### sim/icfr_top_tb.sv
// self-checking bench for the interrupt control and flag registers
`timescale 1ns/1ps
module icfr_top_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, perr, irq_ack, irq_return, irq_high_req, irq_low_req;
	logic        timer0_wrap = 0, port_b_read = 0, parallel_port_access = 0;
	logic        converter_done = 0, serial_rx_full = 0, serial_tx_empty = 0;
	logic        sync_serial_done = 0, en = 0, ret_en = 0, port_pullup_disable;
	logic [2:0]  ext_line_pin = 3'h0;
	logic [3:0]  upper_port_pins = 4'h0, dly = 4'h0;
	int          n_mismatch = 0, checked = 0;
	// 200 mhz clock
	always #2.5 pclk = ~pclk;
	icfr_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer0_wrap(timer0_wrap), .ext_line_pin(ext_line_pin),
		.upper_port_pins(upper_port_pins), .port_b_read(port_b_read),
		.parallel_port_access(parallel_port_access), .converter_done(converter_done),
		.serial_rx_full(serial_rx_full), .serial_tx_empty(serial_tx_empty),
		.sync_serial_done(sync_serial_done), .irq_ack(irq_ack), .irq_return(irq_return),
		.irq_high_req(irq_high_req), .irq_low_req(irq_low_req),
		.port_pullup_disable(port_pullup_disable));
	icfr_core_model core (.pclk(pclk), .presetn(presetn), .irq_high_req(irq_high_req),
		.irq_low_req(irq_low_req), .en(en), .dly(dly), .ret_en(ret_en), .irq_ack(irq_ack),
		.irq_return(irq_return));
	task automatic finish_test;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_mismatch++;
			finish_test();
		end
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, {24'h0, exp});
	endtask : rd
	// m bit 1 waits on the high request, bit 0 on the low one
	task automatic wait_req(input logic [1:0] m);
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (((m[1] & irq_high_req) | (m[0] & irq_low_req)) === 1'b1) break;
		end
		chk({31'h0, i < 20}, 32'h1);
		if (i == 20) finish_test();
	endtask : wait_req
	task automatic t_regs;
		rd(8'h00, 8'h00);
		rd(8'h04, 8'hf5);
		rd(8'h08, 8'hc0);
		rd(8'h0c, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h18, 8'h00);
		chk({31'h0, perr}, 32'h1);
		chk({31'h0, port_pullup_disable}, 32'h1);
		wr(8'h04, 8'hff);
		rd(8'h04, 8'hf5);
		wr(8'h08, 8'hff);
		rd(8'h08, 8'hdb);
		wr(8'h08, 8'hc0);
		wr(8'h04, 8'h75);
		chk({31'h0, port_pullup_disable}, 32'h0);
		wr(8'h04, 8'hf5);
	endtask : t_regs
	// every source fires with all enables off
	task automatic t_flags;
		@(posedge pclk);
		{timer0_wrap, parallel_port_access, converter_done, sync_serial_done} <= 4'hf;
		{serial_rx_full, serial_tx_empty} <= 2'h3;
		ext_line_pin <= 3'h7;
		upper_port_pins <= 4'h5;
		@(posedge pclk);
		{timer0_wrap, parallel_port_access, converter_done, sync_serial_done} <= 4'h0;
		repeat (6) @(posedge pclk);
		rd(8'h00, 8'h07);
		rd(8'h08, 8'hc3);
		rd(8'h0c, 8'hf8);
		// a completion standing through the clearing write survives it
		converter_done <= 1'b1;
		wr(8'h0c, 8'h00);
		converter_done <= 1'b0;
		rd(8'h0c, 8'h70);
		wr(8'h0c, 8'h00);
		rd(8'h0c, 8'h30);
		{serial_rx_full, serial_tx_empty} <= 2'h0;
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h01);
		@(posedge pclk);
		port_b_read <= 1'b1;
		@(posedge pclk);
		port_b_read <= 1'b0;
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h0c, 8'h00);
		wr(8'h08, 8'hc0);
		wr(8'h04, 8'hb5);
		ext_line_pin <= 3'h6;
		repeat (6) @(posedge pclk);
		rd(8'h00, 8'h02);
		rd(8'h08, 8'hc0);
		wr(8'h00, 8'h00);
		wr(8'h04, 8'hf5);
	endtask : t_flags
	task automatic t_compat;
		en <= 1'b1;
		dly <= 4'h2;
		wr(8'h00, 8'h20);
		@(posedge pclk);
		timer0_wrap <= 1'b1;
		@(posedge pclk);
		timer0_wrap <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({31'h0, irq_high_req | irq_low_req}, 32'h0);
		wr(8'h00, 8'ha4);
		wait_req(2'h3);
		repeat (6) @(posedge pclk);
		rd(8'h00, 8'h24);
		wr(8'h00, 8'h20);
		ret_en <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(8'h00, 8'ha0);
		ret_en <= 1'b0;
		@(posedge pclk);
		converter_done <= 1'b1;
		@(posedge pclk);
		converter_done <= 1'b0;
		wr(8'h00, 8'h80);
		repeat (4) @(posedge pclk);
		chk({31'h0, irq_high_req | irq_low_req}, 32'h0);
		wr(8'h00, 8'hc0);
		wait_req(2'h3);
		repeat (6) @(posedge pclk);
		rd(8'h00, 8'h40);
	endtask : t_compat
	// the high service left by t_compat returns first, else the low level stays held off;
	// the converter flag still set from t_compat then rides the low level
	task automatic t_prio;
		en <= 1'b0;
		dly <= 4'h0;
		ret_en <= 1'b1;
		wr(8'h00, 8'h00);
		repeat (6) @(posedge pclk);
		ret_en <= 1'b0;
		rd(8'h00, 8'h80);
		wr(8'h00, 8'h00);
		wr(8'h10, 8'h01);
		rd(8'h10, 8'h01);
		en <= 1'b1;
		wr(8'h00, 8'h40);
		wait_req(2'h1);
		chk({31'h0, irq_high_req}, 32'h0);
		repeat (4) @(posedge pclk);
		rd(8'h14, 8'h01);
		rd(8'h00, 8'h00);
		wr(8'h00, 8'ha0);
		@(posedge pclk);
		timer0_wrap <= 1'b1;
		@(posedge pclk);
		timer0_wrap <= 1'b0;
		wait_req(2'h2);
		repeat (4) @(posedge pclk);
		rd(8'h14, 8'h03);
		rd(8'h00, 8'h24);
		wr(8'h10, 8'h00);
	endtask : t_prio
	// reset for five cycles, then the scenarios in turn
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_flags();
		t_compat();
		t_prio();
		finish_test();
	end
endmodule : icfr_top_tb
